//--- design/flash_host_ctrl.sv
// Purpose: AXI4-Lite driven host that runs bus cycles on a parallel NOR flash
// Assumes: 100 MHz mclk_i, board turns reset_hv_o into the high voltage level
// Notes:   software sequences commands; this block keeps pin timing
`timescale 1ns/1ps
// Operation
// R01: device raises timeout flag bit when its pulse-count limit is exceeded.
// R02: in timeout only status reads work; other functions need a reset.
// R03: after erase timeout, software resets before further program or erase.
// R04: program of non-blank location locks out; toggling persists, timeout rises.
// R05: device powers up in array read mode.
// R06: device alters array only after complete, ordered command sequences.
// R07: high voltage on reset pin unprotects sectors; removing it re-protects.
// R08: hold high voltage for setup time before issuing unprotect-mode commands.
// R09: erase window bit stays low until the sector-erase window expires.
// R10: polling and toggle status valid once first sector erase accepted.
// R11: erase window bit one means further command writes are ignored.
// R12: erase window bit zero means added sector erase commands are accepted.
// R13: software reads erase window bit before and after each added sector.
// R14: strobe pulses below glitch threshold must not start write cycles.
// R15: write only with select and strobe low while output gate high.
// R16: reset during algorithm needs 10 us low; ready within 20 us.
// R17: reset outside algorithm needs 500 ns low; ready within 500 ns.
// R18: after ready rises, wait 50 ns before lowering write strobe.
// R19: failed operation still toggling needs reset command, returning to read.
// R20: each read during an algorithm flips the toggle status bit.
// R21: polling bit reads complement of written data until program completes.
// R22: device times its limits with counters of an internal time base.
module flash_host_ctrl (
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire logic [4:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [4:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [17:0]      flash_addr_o,
  input  wire logic [15:0] flash_dq_i,
  output logic [15:0]      flash_dq_o,
  output logic             flash_dq_oe_o,
  output logic             flash_ce_n_o,
  output logic             flash_oe_n_o,
  output logic             flash_we_n_o,
  output logic             flash_reset_n_o,
  output logic             flash_reset_hv_o,
  input  wire logic        ready_busy_line_i
);

  flash_host_pkg::host_s s_r;
  flash_host_pkg::host_s s_nxt;
  pin_if                 pins ();

  pin_sync u_sync (
    .mclk_i (mclk_i),
    .rst_i  (rst_i),
    .dq_i   (flash_dq_i),
    .rb_i   (ready_busy_line_i),
    .pins   (pins)
  );

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  logic        unprot_ready;
  logic        wr_gate_ok;
  logic        toggling;
  logic [31:0] status_w;
  logic [31:0] ctrl_w;
  logic [31:0] wr_merged;
  logic [11:0] pulse_len;
  logic [11:0] recov_len;

  always_comb begin
    unprot_ready = s_r.hv && (s_r.hv_cnt == flash_host_pkg::C_UNPROT_SETUP);
    // busy line low never blocks: a reset command must get through a hang
    wr_gate_ok   = (!pins.rb || (s_r.rb_cnt == flash_host_pkg::C_BUSY_TO_WR)) && !pins.rb_rise;
    toggling     = (s_r.nreads == 2'h2) &&
                   (s_r.prev[flash_host_pkg::DQ_TOGGLE] !=
                    s_r.rdata[flash_host_pkg::DQ_TOGGLE]);
    status_w = 32'h0000_0000;
    status_w[flash_host_pkg::ST_BUSY]      = (s_r.st != flash_host_pkg::ST_IDLE);
    status_w[flash_host_pkg::ST_RB]        = pins.rb;
    status_w[flash_host_pkg::ST_UNPROT]    = unprot_ready;
    status_w[flash_host_pkg::ST_TOGGLE]    = toggling;                          // [R20]
    status_w[flash_host_pkg::ST_TIMEOUT]   = s_r.rdata[flash_host_pkg::DQ_TIMEOUT]; // [R01]
    status_w[flash_host_pkg::ST_ERASE_WIN] = s_r.rdata[flash_host_pkg::DQ_ERASE_WIN]; // [R13]
    status_w[flash_host_pkg::ST_POLLING]   = s_r.rdata[flash_host_pkg::DQ_POLLING]; // [R21]
    // still toggling with timeout high: software must reset before a new program [R03]
    status_w[flash_host_pkg::ST_FAILED]    = toggling &&
                                             s_r.rdata[flash_host_pkg::DQ_TIMEOUT]; // [R19] [R04]
    ctrl_w = 32'h0000_0000;
    ctrl_w[flash_host_pkg::CTRL_HV] = s_r.hv;
    wr_merged = 32'h0000_0000;
    unique case (s_r.awaddr)
      flash_host_pkg::REG_ADDR:  wr_merged = merge({14'h0000, s_r.addr}, s_r.wd, s_r.ws);
      flash_host_pkg::REG_WDATA: wr_merged = merge({16'h0000, s_r.wdata}, s_r.wd, s_r.ws);
      default:                   wr_merged = merge(ctrl_w, s_r.wd, s_r.ws);
    endcase
    // busy line low at reset time means an algorithm is running
    pulse_len = s_r.long_rst ? flash_host_pkg::C_ALGO_PULSE : flash_host_pkg::C_IDLE_PULSE;
    recov_len = s_r.long_rst ? flash_host_pkg::C_ALGO_RECOV : flash_host_pkg::C_IDLE_RECOV;
  end

  assign s_axi_awready = !s_r.aw_got && !s_r.bvalid;
  assign s_axi_wready  = !s_r.w_got && !s_r.bvalid;
  assign s_axi_arready = !s_r.rvalid;

  always_comb begin
    s_nxt = s_r;
    // unprotect setup timer, cleared when the level is removed
    if (!s_r.hv || !s_r.rst_n) begin
      s_nxt.hv_cnt = 9'h000;
    end else if (s_r.hv_cnt != flash_host_pkg::C_UNPROT_SETUP) begin
      s_nxt.hv_cnt = s_r.hv_cnt + 9'h001;                                       // [R08]
    end
    if (pins.rb_rise) begin
      s_nxt.rb_cnt = 3'h0;                                                      // [R18]
    end else if (s_r.rb_cnt != flash_host_pkg::C_BUSY_TO_WR) begin
      s_nxt.rb_cnt = s_r.rb_cnt + 3'h1;
    end

    // axi write side
    if (s_axi_awvalid && s_axi_awready) begin
      s_nxt.aw_got = 1'b1;
      s_nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_nxt.w_got = 1'b1;
      s_nxt.wd    = s_axi_wdata;
      s_nxt.ws    = s_axi_wstrb;
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (s_r.aw_got && s_r.w_got) begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got  = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp  = flash_host_pkg::RESP_OKAY;
      unique case (s_r.awaddr)
        flash_host_pkg::REG_CTRL: begin
          if (s_r.ws[0]) begin
            s_nxt.hv = wr_merged[flash_host_pkg::CTRL_HV];                      // [R07]
            // a start while a cycle runs is dropped
            if (s_r.st == flash_host_pkg::ST_IDLE) begin
              if (wr_merged[flash_host_pkg::CTRL_RESET]) begin
                s_nxt.st       = flash_host_pkg::ST_RSTP;
                s_nxt.cnt      = 12'h000;
                s_nxt.long_rst = !pins.rb;                                      // [R16] [R17]
                s_nxt.rst_n    = 1'b0;
              end else if (wr_merged[flash_host_pkg::CTRL_WRITE] ||
                           wr_merged[flash_host_pkg::CTRL_READ]) begin
                s_nxt.st    = flash_host_pkg::ST_ARM;
                s_nxt.op_wr = wr_merged[flash_host_pkg::CTRL_WRITE];
              end
            end
          end
        end
        flash_host_pkg::REG_ADDR:  s_nxt.addr  = wr_merged[17:0];
        flash_host_pkg::REG_WDATA: s_nxt.wdata = wr_merged[15:0];
        flash_host_pkg::REG_RDATA,
        flash_host_pkg::REG_STATUS: s_nxt.bresp = flash_host_pkg::RESP_OKAY;
        default:                   s_nxt.bresp = flash_host_pkg::RESP_DECERR;
      endcase
    end

    // axi read side
    if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp  = flash_host_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        flash_host_pkg::REG_CTRL:   s_nxt.rd = ctrl_w;
        flash_host_pkg::REG_ADDR:   s_nxt.rd = {14'h0000, s_r.addr};
        flash_host_pkg::REG_WDATA:  s_nxt.rd = {16'h0000, s_r.wdata};
        flash_host_pkg::REG_RDATA:  s_nxt.rd = {16'h0000, s_r.rdata};
        flash_host_pkg::REG_STATUS: s_nxt.rd = status_w;
        default: begin
          s_nxt.rd    = 32'h0000_0000;
          s_nxt.rresp = flash_host_pkg::RESP_DECERR;
        end
      endcase
    end

    // flash bus cycle engine
    unique case (s_r.st)
      flash_host_pkg::ST_IDLE: begin
        s_nxt.cnt = 12'h000;
      end
      flash_host_pkg::ST_ARM: begin
        s_nxt.cnt = 12'h000;
        // hold off until unprotect setup time has run out
        if (!s_r.hv || unprot_ready) begin                                      // [R08]
          if (!s_r.op_wr) begin
            s_nxt.st   = flash_host_pkg::ST_ACC;
            s_nxt.ce_n = 1'b0;
            s_nxt.oe_n = 1'b0;
          end else if (wr_gate_ok) begin                                        // [R18]
            // output gate stays high for the whole write
            s_nxt.st    = flash_host_pkg::ST_STROBE;
            s_nxt.oe_n  = 1'b1;
            s_nxt.ce_n  = 1'b0;
            s_nxt.we_n  = 1'b0;                                                 // [R15]
            s_nxt.dq_oe = 1'b1;
          end
        end
      end
      flash_host_pkg::ST_STROBE: begin
        // strobe held well past the glitch threshold so it is always seen
        if (s_r.cnt == flash_host_pkg::C_WE_PULSE - 12'h001) begin              // [R14]
          s_nxt.st   = flash_host_pkg::ST_GAP;
          s_nxt.cnt  = 12'h000;
          s_nxt.we_n = 1'b1;
          s_nxt.ce_n = 1'b1;
        end else begin
          s_nxt.cnt = s_r.cnt + 12'h001;
        end
      end
      flash_host_pkg::ST_ACC: begin
        // covers access time plus synchroniser latency
        if (s_r.cnt == flash_host_pkg::C_ACCESS - 12'h001) begin
          s_nxt.st     = flash_host_pkg::ST_GAP;
          s_nxt.cnt    = 12'h000;
          s_nxt.ce_n   = 1'b1;
          s_nxt.oe_n   = 1'b1;
          s_nxt.prev   = s_r.rdata;
          s_nxt.rdata  = pins.dq;                                               // [R20] [R21]
          s_nxt.nreads = (s_r.nreads == 2'h2) ? 2'h2 : s_r.nreads + 2'h1;
        end else begin
          s_nxt.cnt = s_r.cnt + 12'h001;
        end
      end
      flash_host_pkg::ST_GAP: begin
        s_nxt.dq_oe = 1'b0;
        if (s_r.cnt == flash_host_pkg::C_WE_HIGH - 12'h001) begin
          s_nxt.st  = flash_host_pkg::ST_IDLE;
          s_nxt.cnt = 12'h000;
        end else begin
          s_nxt.cnt = s_r.cnt + 12'h001;
        end
      end
      flash_host_pkg::ST_RSTP: begin
        // reset pin released after the pulse, done once recovery elapses
        if (s_r.cnt == pulse_len - 12'h001) begin
          s_nxt.rst_n = 1'b1;                                                   // [R16] [R17]
        end
        if (s_r.cnt >= pulse_len - 12'h001 && s_r.cnt >= recov_len - 12'h001) begin
          s_nxt.st     = flash_host_pkg::ST_IDLE;
          s_nxt.cnt    = 12'h000;
          s_nxt.nreads = 2'h0;
        end else begin
          s_nxt.cnt = s_r.cnt + 12'h001;
        end
      end
      default: begin
        s_nxt.st = flash_host_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      s_r <= flash_host_pkg::HOST_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign s_axi_bvalid     = s_r.bvalid;
  assign s_axi_bresp      = s_r.bresp;
  assign s_axi_rvalid     = s_r.rvalid;
  assign s_axi_rdata      = s_r.rd;
  assign s_axi_rresp      = s_r.rresp;
  assign flash_addr_o     = s_r.addr;
  assign flash_dq_o       = s_r.wdata;
  assign flash_dq_oe_o    = s_r.dq_oe;
  assign flash_ce_n_o     = s_r.ce_n;
  assign flash_oe_n_o     = s_r.oe_n;
  assign flash_we_n_o     = s_r.we_n;
  assign flash_reset_n_o  = s_r.rst_n;
  // high voltage is never requested while the pin is pulsed low
  assign flash_reset_hv_o = s_r.hv && s_r.rst_n;                                // [R07]

endmodule : flash_host_ctrl

//--- design/flash_host_pkg.sv
// Purpose: shared constants and types of the flash host controller
// Assumes: 100 MHz mclk_i, 16-bit flash data bus, 18-bit word address
// Notes:   time figures are in their printed units, counts derive from them
package flash_host_pkg;

  localparam int CLK_PERIOD_NS = 10;

  // timing figures
  localparam int T_WE_PULSE_NS     = 35;   // write strobe low, far above glitch threshold
  localparam int T_WE_HIGH_NS      = 20;   // strobe high / bus float gap
  localparam int T_ACCESS_NS       = 90;   // read access
  localparam int T_BUSY_TO_WR_NS   = 50;   // busy_release_to_write
  localparam int T_UNPROT_SETUP_US = 4;    // unprotect_setup_time
  localparam int T_ALGO_PULSE_US   = 10;   // algo_reset_pulse
  localparam int T_IDLE_PULSE_NS   = 500;  // idle_reset_pulse
  localparam int T_ALGO_RECOV_US   = 20;   // algo_reset_recovery
  localparam int T_IDLE_RECOV_NS   = 500;  // idle_reset_recovery
  localparam int SYNC_LAT          = 3;    // pin synchroniser depth

  // least times, rounded up to whole cycles
  localparam logic [11:0] C_WE_PULSE =
    12'((T_WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] C_WE_HIGH =
    12'((T_WE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] C_ACCESS =
    12'((T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_LAT);
  localparam logic [2:0] C_BUSY_TO_WR =
    3'((T_BUSY_TO_WR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [8:0] C_UNPROT_SETUP =
    9'((T_UNPROT_SETUP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] C_ALGO_PULSE =
    12'((T_ALGO_PULSE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] C_IDLE_PULSE =
    12'((T_IDLE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] C_ALGO_RECOV =
    12'((T_ALGO_RECOV_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] C_IDLE_RECOV =
    12'((T_IDLE_RECOV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // register offsets
  localparam logic [4:0] REG_CTRL   = 5'h00;
  localparam logic [4:0] REG_ADDR   = 5'h04;
  localparam logic [4:0] REG_WDATA  = 5'h08;
  localparam logic [4:0] REG_RDATA  = 5'h0c;
  localparam logic [4:0] REG_STATUS = 5'h10;

  // ctrl fields
  localparam int CTRL_READ  = 0;
  localparam int CTRL_WRITE = 1;
  localparam int CTRL_RESET = 2;
  localparam int CTRL_HV    = 3;

  // status fields
  localparam int ST_BUSY     = 0;
  localparam int ST_RB       = 1;
  localparam int ST_UNPROT   = 2;
  localparam int ST_TOGGLE   = 3;
  localparam int ST_TIMEOUT  = 4;
  localparam int ST_ERASE_WIN = 5;
  localparam int ST_POLLING  = 6;
  localparam int ST_FAILED   = 7;

  // status bit positions in flash data
  localparam int DQ_POLLING  = 7;
  localparam int DQ_TOGGLE   = 6;
  localparam int DQ_TIMEOUT  = 5;
  localparam int DQ_ERASE_WIN = 3;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_ARM    = 3'h1,
    ST_STROBE = 3'h2,
    ST_ACC    = 3'h3,
    ST_GAP    = 3'h4,
    ST_RSTP   = 3'h5
  } cyc_e;

  typedef struct packed {
    cyc_e        st;
    logic [11:0] cnt;
    logic        op_wr;
    logic        long_rst;
    logic [17:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic [15:0] prev;
    logic [1:0]  nreads;
    logic        hv;
    logic [8:0]  hv_cnt;
    logic [2:0]  rb_cnt;
    logic        aw_got;
    logic [4:0]  awaddr;
    logic        w_got;
    logic [31:0] wd;
    logic [3:0]  ws;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rd;
    logic [1:0]  rresp;
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
    logic        rst_n;
    logic        dq_oe;
  } host_s;

  localparam host_s HOST_RST = '{
    st: ST_IDLE, cnt: 12'h000, op_wr: 1'b0, long_rst: 1'b0, addr: 18'h00000,
    wdata: 16'h0000, rdata: 16'h0000, prev: 16'h0000, nreads: 2'h0,
    hv: 1'b0, hv_cnt: 9'h000, rb_cnt: C_BUSY_TO_WR, aw_got: 1'b0,
    awaddr: 5'h00, w_got: 1'b0, wd: 32'h0000_0000, ws: 4'h0,
    bvalid: 1'b0, bresp: 2'h0, rvalid: 1'b0, rd: 32'h0000_0000, rresp: 2'h0,
    ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, rst_n: 1'b1, dq_oe: 1'b0};

  typedef struct packed {
    logic [16:0] s1;
    logic [16:0] s2;
    logic [16:0] s3;
    logic [16:0] stable;
    logic        rise;
  } sync_s;

  localparam sync_s SYNC_RST = '{
    s1: 17'h1ffff, s2: 17'h1ffff, s3: 17'h1ffff, stable: 17'h1ffff, rise: 1'b0};

endpackage : flash_host_pkg

//--- design/pin_if.sv
// Purpose: carries filtered flash pin levels from the synchroniser
// Assumes: single mclk_i domain
// Notes:   rb_rise is a one-cycle pulse
`timescale 1ns/1ps
interface pin_if;
  logic [15:0] dq;
  logic        rb;
  logic        rb_rise;
  modport src (output dq, output rb, output rb_rise);
  modport dst (input dq, input rb, input rb_rise);
endinterface : pin_if

//--- design/pin_sync.sv
// Purpose: three-flop synchroniser for flash data and ready/busy pins
// Assumes: pins are asynchronous to mclk_i
// Notes:   a level counts once flops two and three agree
`timescale 1ns/1ps
module pin_sync (
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire logic [15:0] dq_i,
  input  wire logic        rb_i,
  pin_if.src               pins
);

  flash_host_pkg::sync_s s_r;
  flash_host_pkg::sync_s s_nxt;

  always_comb begin
    s_nxt      = s_r;
    s_nxt.s1   = {rb_i, dq_i};
    s_nxt.s2   = s_r.s1;
    s_nxt.s3   = s_r.s2;
    // s1 feeds only s2
    for (int i = 0; i < 17; i++) begin
      if (s_r.s2[i] == s_r.s3[i]) begin
        s_nxt.stable[i] = s_r.s3[i];
      end
    end
    s_nxt.rise = s_nxt.stable[16] & ~s_r.stable[16];
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      s_r <= flash_host_pkg::SYNC_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign pins.dq      = s_r.stable[15:0];
  assign pins.rb      = s_r.stable[16];
  assign pins.rb_rise = s_r.rise;

endmodule : pin_sync

//--- dv/flash_host_ctrl_asserts.sv
// Purpose: port checks of flash_host_ctrl
// Assumes: one clock, rst_i active high
// Notes: counters stand in for long repeats
`timescale 1ns/1ps
module flash_host_ctrl_asserts (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic flash_ce_n_o,
  input wire logic flash_oe_n_o,
  input wire logic flash_we_n_o,
  input wire logic flash_dq_oe_o,
  input wire logic flash_reset_n_o,
  input wire logic flash_reset_hv_o,
  input wire logic ready_busy_line_i
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  logic [10:0] low_c;
  logic [9:0]  hv_c;
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      low_c <= 11'h000;
      hv_c  <= 10'h000;
    end else begin
      low_c <= flash_reset_n_o ? 11'h000 : low_c + 11'h001;
      hv_c  <= !flash_reset_hv_o ? 10'h000 : hv_c + {9'h000, hv_c != 10'h3ff};
    end
  end
  sequence s_we_low;
    !flash_we_n_o [*4];
  endsequence
  sequence s_we_quiet;
    flash_we_n_o [*5];
  endsequence
  a_write_gate: assert property (!flash_we_n_o |-> !flash_ce_n_o && flash_oe_n_o)
    else $error("write strobe outside select");
  a_we_data: assert property (!flash_we_n_o |-> flash_dq_oe_o)
    else $error("write strobe without data drive");
  a_read_quiet: assert property (!flash_oe_n_o |-> flash_we_n_o && !flash_dq_oe_o)
    else $error("read gate with write activity");
  a_we_width: assert property ($fell(flash_we_n_o) |-> s_we_low)
    else $error("write strobe too short");
  a_busy_gap: assert property ($rose(ready_busy_line_i) && flash_we_n_o |-> s_we_quiet)
    else $error("strobe too soon after ready");
  a_hv_in_rst: assert property (!flash_reset_n_o |-> !flash_reset_hv_o)
    else $error("high voltage during reset pulse");
  a_rst_width: assert property ($rose(flash_reset_n_o) |-> low_c >= 11'h032)
    else $error("reset pulse too short");
  a_hv_setup: assert property ($fell(flash_ce_n_o) && flash_reset_hv_o |-> hv_c >= 10'h190)
    else $error("select before unprotect setup");
endmodule : flash_host_ctrl_asserts
bind flash_host_ctrl flash_host_ctrl_asserts i_chk (.mclk_i, .rst_i, .flash_ce_n_o,
  .flash_oe_n_o, .flash_we_n_o, .flash_dq_oe_o, .flash_reset_n_o, .flash_reset_hv_o,
  .ready_busy_line_i);

//--- dv/flash_dev_model.sv
// Purpose: behavioural flash device facing flash_host_ctrl
// Assumes: clk_i only paces the internal time base
// Notes: a write taken while idle programs; data 16'h0030 opens a sector erase
`timescale 1ns/1ps
module flash_dev_model #(
  parameter int LIM  = 300,
  parameter int PROG = 200,
  parameter int WIN  = 60
) (
  input  wire logic        clk_i,
  input  wire logic [17:0] addr_i,
  input  wire logic [15:0] dq_i,
  input  wire logic        ce_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        we_n_i,
  input  wire logic        rst_n_i,
  output logic [15:0]      dq_o,
  output logic             rb_o
);
  logic [15:0] mem [0:15];
  logic [15:0] wd = 16'h0000;
  logic [15:0] rd = 16'h0000;
  logic        busy = 1'b0;
  logic        lock = 1'b0;
  logic        ers = 1'b0;
  logic        tog = 1'b0;
  logic        tmo = 1'b0;
  int          t = 0;
  realtime     tf = 0;
  wire         wr = !ce_n_i && !we_n_i && oe_n_i;
  wire         rdg = !ce_n_i && !oe_n_i;
  initial foreach (mem[i]) mem[i] = 16'hffff;
  assign rb_o = !busy;
  // released bus shows the inverse, never a stale value
  assign dq_o = rdg ? rd : ~rd;
  always @(posedge wr) tf = $realtime;
  always @(negedge wr) begin
    if (rst_n_i && $realtime - tf >= 5.0 &&
        (!busy || (ers && t < WIN && dq_i == 16'h0030))) begin
      wd = dq_i;
      busy = 1'b1;
      t = 0;
      ers = dq_i == 16'h0030;
      lock = !ers && mem[addr_i[3:0]] !== 16'hffff;
      if (!ers && !lock) mem[addr_i[3:0]] = dq_i;
    end
  end
  always @(negedge clk_i) begin
    if (!rst_n_i) begin
      busy = 1'b0;
      tmo = 1'b0;
    end else if (busy) begin
      t = t + 1;
      if (lock && t >= LIM) tmo = 1'b1;
      if (!lock && t >= PROG + (ers ? WIN : 0)) busy = 1'b0;
    end
  end
  always @(posedge rdg) begin
    rd = mem[addr_i[3:0]];
    if (busy) begin
      tog = !tog;
      rd = {8'h00, !ers && !wd[7], tog, tmo, 1'b0, ers && t >= WIN, 3'h0};
    end
  end
endmodule : flash_dev_model

//--- dv/flash_host_ctrl_tb.sv
// Purpose: self-checking bench of flash_host_ctrl with a device model
// Assumes: model time base shares mclk_i
// Notes: fixed seed; bready and rready held high, legal for the bus
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin failures++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module flash_host_ctrl_tb;
  localparam logic [4:0] CTL = flash_host_pkg::REG_CTRL;
  localparam logic [4:0] ADR = flash_host_pkg::REG_ADDR;
  localparam logic [4:0] WDA = flash_host_pkg::REG_WDATA;
  localparam logic [4:0] RDA = flash_host_pkg::REG_RDATA;
  localparam logic [4:0] STA = flash_host_pkg::REG_STATUS;
  localparam logic [1:0] OK = flash_host_pkg::RESP_OKAY;
  localparam logic [1:0] DEC = flash_host_pkg::RESP_DECERR;
  logic mclk_i = 1'b0, rst_i = 1'b1, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic [4:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [17:0] flash_addr_o, a;
  logic [15:0] flash_dq_i, flash_dq_o, d;
  logic flash_dq_oe_o, flash_ce_n_o, flash_oe_n_o, flash_we_n_o;
  logic flash_reset_n_o, flash_reset_hv_o, ready_busy_line_i;
  int failures = 0, num_checks = 0, low_c = 0, n;
  flash_host_ctrl i_dut (.mclk_i, .rst_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .flash_addr_o, .flash_dq_i, .flash_dq_o, .flash_dq_oe_o,
    .flash_ce_n_o, .flash_oe_n_o, .flash_we_n_o, .flash_reset_n_o, .flash_reset_hv_o,
    .ready_busy_line_i);
  flash_dev_model i_dev (.clk_i(mclk_i), .addr_i(flash_addr_o), .dq_i(flash_dq_o),
    .ce_n_i(flash_ce_n_o), .oe_n_i(flash_oe_n_o), .we_n_i(flash_we_n_o),
    .rst_n_i(flash_reset_n_o), .dq_o(flash_dq_i), .rb_o(ready_busy_line_i));
  always #5 mclk_i = ~mclk_i;
  always @(posedge mclk_i) if (!flash_reset_n_o) low_c <= low_c + 1;
  task automatic wrap_up();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : wrap_up
  task automatic hang(input int k, input int lim);
    if (k >= lim) begin
      failures++;
      wrap_up();
    end
  endtask : hang
  task automatic axi_wr(input logic [4:0] ad, input logic [31:0] dt, input logic [1:0] er);
    int k;
    k = 0;
    s_axi_awaddr <= ad;
    s_axi_wdata <= dt;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge mclk_i);
      k++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && k < 200);
    hang(k, 200);
    `CHK(s_axi_bresp, er)
  endtask : axi_wr
  task automatic axi_rd(input logic [4:0] ad, input logic [1:0] er);
    int k;
    k = 0;
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge mclk_i);
      k++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && k < 200);
    hang(k, 200);
    rv = s_axi_rdata;
    `CHK(s_axi_rresp, er)
  endtask : axi_rd
  // poll one status bit; a register read is the only view of it
  task automatic poll(input int b, input logic v);
    int k;
    k = 0;
    do begin
      axi_rd(STA, OK);
      k++;
    end while (rv[b] !== v && k < 2000);
    hang(k, 2000);
  endtask : poll
  task automatic op(input logic [31:0] c);
    axi_wr(CTL, c, OK);
    poll(0, 1'b0);
  endtask : op
  initial begin
    void'($urandom(41310));
    repeat (8) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(posedge mclk_i);
    axi_rd(STA, OK);
    `CHK(rv, 32'h0000_0002)
    axi_rd(5'h14, DEC);
    `CHK(rv, 32'h0000_0000)
    axi_wr(5'h14, 32'h0000_0001, DEC);
    axi_wr(RDA, 32'h0000_ffff, OK);
    axi_rd(RDA, OK);
    `CHK(rv, 32'h0000_0000)
    $display("test map done");
    a = 18'($urandom);
    d = 16'($urandom) & 16'hfefe | 16'h0100;
    axi_wr(ADR, {14'h0, a}, OK);
    axi_wr(WDA, {16'h0, d}, OK);
    op(32'h2);
    op(32'h1);
    op(32'h1);
    axi_rd(STA, OK);
    `CHK(rv[6], ~d[7])
    `CHK(rv[3], 1'b1)
    poll(1, 1'b1);
    op(32'h1);
    op(32'h1);
    axi_rd(RDA, OK);
    `CHK(rv, {16'h0, d})
    $display("test program done");
    axi_wr(WDA, {16'h0, ~d}, OK);
    op(32'h2);
    n = 0;
    do begin
      op(32'h1);
      axi_rd(STA, OK);
      n++;
    end while (rv[4] !== 1'b1 && n < 100);
    `CHK(rv[7], 1'b1)
    n = low_c;
    op(32'h4);
    `CHK(low_c - n >= 1000, 1'b1)
    op(32'h1);
    op(32'h1);
    axi_rd(STA, OK);
    `CHK(rv[3], 1'b0)
    axi_rd(RDA, OK);
    `CHK(rv, {16'h0, d})
    n = low_c;
    op(32'h4);
    `CHK(low_c - n >= 50, 1'b1)
    $display("test lockout done");
    axi_wr(WDA, 32'h0000_0030, OK);
    op(32'h2);
    op(32'h1);
    axi_rd(STA, OK);
    `CHK(rv[6:5], 2'b00)
    n = 0;
    do begin
      op(32'h1);
      axi_rd(STA, OK);
      n++;
    end while (rv[5] !== 1'b1 && n < 50);
    `CHK(rv[5], 1'b1)
    poll(1, 1'b1);
    $display("test erase done");
    axi_wr(CTL, 32'h8, OK);
    `CHK(flash_reset_hv_o, 1'b1)
    axi_rd(CTL, OK);
    `CHK(rv, 32'h0000_0008)
    op(32'h9);
    `CHK(rv[2], 1'b1)
    axi_wr(CTL, 32'h0, OK);
    `CHK(flash_reset_hv_o, 1'b0)
    $display("test unprotect done");
    wrap_up();
  end
endmodule : flash_host_ctrl_tb
